// *** hdl/ccpc_params.svh ***
// Constants of the card command parameter checker
`ifndef CCPC_PARAMS_SVH
`define CCPC_PARAMS_SVH
`define CCPC_NUM_EF      4
`define CCPC_EF_W        2
`define CCPC_FID_BASE    16'h6f00
`define CCPC_BUF_DEPTH   8'h20
`define CCPC_BUF_AW      5
`define CCPC_ZERO        8'h00
`define CCPC_INS_REACT   8'h01
`define CCPC_INS_AUTH    8'h02
`define CCPC_INS_TPROF   8'h03
`define CCPC_INS_ENV     8'h04
`define CCPC_INS_FETCH   8'h05
`define CCPC_INS_TRESP   8'h06
`define CCPC_INS_GETRSP  8'h07
`define CCPC_P1_BY_FID   8'h00
`define CCPC_P1_PATH_MF  8'h08
`define CCPC_P1_PATH_DF  8'h09
`define CCPC_P2_SPEC     7
`define CCPC_P2_RFU_HI   6
`define CCPC_P2_RFU_LO   5
`define CCPC_P2_REF_HI   4
`define CCPC_FID_LEN     8'h02
`define CCPC_SW_OK       16'h9000
`define CCPC_SW_TECH     16'h6f00
`define CCPC_SW_BADP     16'h6b00
`define CCPC_SW_ACCESS   16'h6982
`define CCPC_SW_NOFILE   16'h6a82
`define CCPC_SW_LEN      16'h6700
`define CCPC_SW_INS      16'h6d00
`define CCPC_SW1_AVAIL   8'h61
`define CCPC_SW1_RELEN   8'h6c
`endif

// *** hdl/ccpc_pkg.sv ***
// Types of the card end and the terminal end of the card command link, each used by one end
package ccpc_pkg;
	typedef enum logic [2:0] {
		C_IDLE = 3'h0, C_DATA = 3'h1, C_EXEC = 3'h3, C_SEND = 3'h2, C_STAT = 3'h6
	} ccpc_card_st_t;
	typedef enum logic [1:0] {
		T_IDLE = 2'h0, T_HDR = 2'h1, T_DATA = 2'h3, T_WAIT = 2'h2
	} ccpc_term_st_t;
	typedef enum logic [1:0] {
		TK_PROFILE = 2'h0, TK_TOOLKIT_CMD_A = 2'h1, TK_TRESP = 2'h2
	} ccpc_tk_kind_t;
endpackage

// *** hdl/ccpc_link_if.sv ***
// Command, data, response and status link between terminal and card
`timescale 1ns/100ps
interface ccpc_link_if;
	logic        cmd_valid;
	logic        cmd_ready;
	logic [7:0]  ins;
	logic [7:0]  p1;
	logic [7:0]  p2;
	logic [7:0]  lc;
	logic        lc_present;
	logic [7:0]  le;
	logic        le_present;
	logic        dat_valid;
	logic        dat_ready;
	logic [7:0]  dat_byte;
	logic        rsp_valid;
	logic        rsp_ready;
	logic [7:0]  rsp_byte;
	logic        sw_valid;
	logic [15:0] sw;
	modport card (input cmd_valid, ins, p1, p2, lc, lc_present, le, le_present,
		dat_valid, dat_byte, rsp_ready, output cmd_ready, dat_ready, rsp_valid,
		rsp_byte, sw_valid, sw);
	modport term (output cmd_valid, ins, p1, p2, lc, lc_present, le, le_present,
		dat_valid, dat_byte, rsp_ready, input cmd_ready, dat_ready, rsp_valid,
		rsp_byte, sw_valid, sw);
endinterface

// *** hdl/ccpc_card_end.sv ***
// Card end: parameter checks, file reactivation, authentication, toolkit, retrieval
`timescale 1ns/100ps
`include "ccpc_params.svh"
module ccpc_card_end (
	input  wire logic                   core_clk,
	input  wire logic                   resetn,
	input  wire logic                   ce,
	ccpc_link_if.card                   lnk,
	input  wire logic [`CCPC_NUM_EF-1:0] ac_ok,
	input  wire logic [`CCPC_NUM_EF-1:0] deact_req,
	output logic [`CCPC_NUM_EF-1:0]      lcs_active,
	output logic [`CCPC_EF_W-1:0]        cur_ef,
	output logic                         cur_ef_valid,
	output logic                         key_specific,
	output logic                         key_implicit,
	output logic [4:0]                   key_ref,
	input  wire logic [7:0]              key_byte,
	output logic                         tk_valid,
	output ccpc_pkg::ccpc_tk_kind_t      tk_kind,
	output logic [7:0]                   tk_byte,
	input  wire logic                    ext_wr,
	input  wire logic [`CCPC_BUF_AW-1:0] ext_addr,
	input  wire logic [7:0]              ext_byte,
	input  wire logic                    ext_set,
	input  wire logic [7:0]              ext_len,
	input  wire logic                    pro_set,
	input  wire logic [7:0]              pro_len
);
	import ccpc_pkg::*;

	ccpc_card_st_t             st_q, st_d;
	logic [7:0]                ins_q, p1_q, p2_q, lc_q, le_q, ins_d, p1_d, p2_d, lc_d, le_d;
	logic                      lep_q, lep_d, lcp_q, lcp_d;
	logic [15:0]               fid_q, fid_d, sw_q, sw_d;
	logic [7:0]                idx_q, idx_d, len_q, len_d, rsp_q, rsp_d;
	logic [`CCPC_NUM_EF-1:0]   act_q, act_d;
	logic [`CCPC_EF_W-1:0]     ef_q, ef_d;
	logic                      ef_ok_q, ef_ok_d, pend_q, pend_d, first_q, first_d;
	logic [7:0]                pend_len_q, pend_len_d, pro_len_q, pro_len_d;
	logic                      tk_v_q, tk_v_d;
	ccpc_tk_kind_t             tk_k_q, tk_k_d;
	logic [7:0]                tk_b_q, tk_b_d;
	logic [7:0]                buf_mem [0:`CCPC_BUF_DEPTH-1];
	logic [`CCPC_EF_W:0]       hit;

	function automatic logic p_zero(input logic [7:0] a, input logic [7:0] b);
		return (a == `CCPC_ZERO) && (b == `CCPC_ZERO);
	endfunction

	// Returns {found, index} for a file identifier
	function automatic logic [`CCPC_EF_W:0] fid_find(input logic [15:0] f);
		logic [`CCPC_EF_W:0] r;
		r = '0;
		for (int i = 0; i < `CCPC_NUM_EF; i++) begin
			if (f == `CCPC_FID_BASE + 16'(i))
				r = {1'b1, `CCPC_EF_W'(i)};
		end
		return r;
	endfunction

	function automatic logic [7:0] min8(input logic [7:0] a, input logic [7:0] b);
		return (a < b) ? a : b;
	endfunction

	assign lnk.cmd_ready = (st_q == C_IDLE);
	assign lnk.dat_ready = (st_q == C_DATA);
	assign lnk.rsp_valid = (st_q == C_SEND);
	assign lnk.sw_valid  = (st_q == C_STAT);
	assign lnk.rsp_byte  = rsp_q;
	assign lnk.sw        = sw_q;
	assign lcs_active    = act_q;
	assign cur_ef        = ef_q;
	assign cur_ef_valid  = ef_ok_q;
	assign key_specific  = p2_q[`CCPC_P2_SPEC];
	assign key_implicit  = (p2_q == `CCPC_ZERO);
	assign key_ref       = p2_q[`CCPC_P2_REF_HI:0];
	assign tk_valid      = tk_v_q;
	assign tk_kind       = tk_k_q;
	assign tk_byte       = tk_b_q;
	assign hit           = fid_find(fid_q);

	always_comb begin
		st_d = st_q; ins_d = ins_q; p1_d = p1_q; p2_d = p2_q; lc_d = lc_q; le_d = le_q;
		lep_d = lep_q; lcp_d = lcp_q; fid_d = fid_q; sw_d = sw_q; idx_d = idx_q;
		len_d = len_q; rsp_d = rsp_q; act_d = act_q & ~deact_req; ef_d = ef_q;
		ef_ok_d = ef_ok_q; pend_d = pend_q; pend_len_d = pend_len_q; first_d = first_q;
		pro_len_d = pro_set ? pro_len : pro_len_q;
		tk_v_d = 1'b0; tk_k_d = tk_k_q; tk_b_d = tk_b_q;
		case (st_q)
			C_IDLE: begin
				if (lnk.cmd_valid) begin
					ins_d = lnk.ins; p1_d = lnk.p1; p2_d = lnk.p2;
					lc_d = lnk.lc_present ? lnk.lc : `CCPC_ZERO;
					lcp_d = lnk.lc_present; lep_d = lnk.le_present;
					le_d = lnk.le; idx_d = '0; fid_d = '0;
					st_d = (lnk.lc_present && lnk.lc != `CCPC_ZERO) ? C_DATA : C_EXEC;
				end
			end
			C_DATA: begin
				if (lnk.dat_valid) begin
					fid_d = {fid_q[7:0], lnk.dat_byte};
					idx_d = idx_q + 8'h01;
					tk_b_d = lnk.dat_byte;
					tk_v_d = (ins_q == `CCPC_INS_TPROF) || (ins_q == `CCPC_INS_ENV) ||
						(ins_q == `CCPC_INS_TRESP);
					tk_k_d = (ins_q == `CCPC_INS_TPROF) ? TK_PROFILE :
						(ins_q == `CCPC_INS_ENV) ? TK_TOOLKIT_CMD_A : TK_TRESP;
					if (idx_d == lc_q)
						st_d = C_EXEC;
				end
			end
			C_EXEC: begin
				// Any command except a retrieval answered with a wrong-length status breaks the retrieval chain
				pend_d = 1'b0;
				first_d = 1'b0;
				len_d = '0;
				sw_d = `CCPC_SW_OK;
				case (ins_q)
					`CCPC_INS_REACT: begin
						if (p2_q != `CCPC_ZERO || (p1_q != `CCPC_P1_BY_FID &&
							p1_q != `CCPC_P1_PATH_MF && p1_q != `CCPC_P1_PATH_DF))
							sw_d = `CCPC_SW_BADP;
						else if (lc_q == `CCPC_ZERO && p1_q != `CCPC_P1_BY_FID)
							sw_d = `CCPC_SW_LEN;
						else if (lc_q == `CCPC_ZERO) begin
							if (!ef_ok_q)
								sw_d = `CCPC_SW_NOFILE;
							else if (!ac_ok[ef_q])
								sw_d = `CCPC_SW_ACCESS;
							else
								act_d[ef_q] = 1'b1;
						end else if ((p1_q == `CCPC_P1_BY_FID && lc_q != `CCPC_FID_LEN) ||
							lc_q[0] || lc_q < `CCPC_FID_LEN)
							sw_d = `CCPC_SW_LEN;
						else if (!hit[`CCPC_EF_W])
							sw_d = `CCPC_SW_NOFILE;
						else if (!ac_ok[hit[`CCPC_EF_W-1:0]])
							sw_d = `CCPC_SW_ACCESS;
						else begin
							act_d[hit[`CCPC_EF_W-1:0]] = 1'b1;
							ef_d = hit[`CCPC_EF_W-1:0];
							ef_ok_d = 1'b1;
						end
					end
					`CCPC_INS_AUTH: begin
						if (p1_q != `CCPC_ZERO ||
							p2_q[`CCPC_P2_RFU_HI:`CCPC_P2_RFU_LO] != 2'h0 ||
							(p2_q != `CCPC_ZERO && p2_q[`CCPC_P2_REF_HI:0] == 5'h00))
							sw_d = `CCPC_SW_BADP;
						else if (lc_q == `CCPC_ZERO || lc_q > `CCPC_BUF_DEPTH)
							sw_d = `CCPC_SW_LEN;
						else begin
							pend_d = 1'b1;
							pend_len_d = (lep_q && le_q != `CCPC_ZERO) ?
								min8(le_q, `CCPC_BUF_DEPTH) : lc_q;
							sw_d = {`CCPC_SW1_AVAIL, pend_len_d};
						end
					end
					`CCPC_INS_TPROF, `CCPC_INS_ENV, `CCPC_INS_TRESP: begin
						if (!p_zero(p1_q, p2_q))
							sw_d = `CCPC_SW_BADP;
					end
					`CCPC_INS_FETCH: begin
						if (!p_zero(p1_q, p2_q))
							sw_d = `CCPC_SW_BADP;
						else begin
							len_d = min8(pro_len_q, `CCPC_BUF_DEPTH);
							pro_len_d = pro_set ? pro_len : `CCPC_ZERO;
						end
					end
					`CCPC_INS_GETRSP: begin
						if (!p_zero(p1_q, p2_q))
							sw_d = `CCPC_SW_BADP;
						else if (pend_q) begin
							if (lep_q && le_q != `CCPC_ZERO && le_q != pend_len_q) begin
								sw_d = {`CCPC_SW1_RELEN, pend_len_q};
								pend_d = 1'b1;
							end else
								len_d = pend_len_q;
						end else if (!first_q)
							sw_d = `CCPC_SW_TECH;
						// First command after reset answers with no data
					end
					default: sw_d = `CCPC_SW_INS;
				endcase
				idx_d = '0;
				rsp_d = buf_mem[0];
				st_d = (len_d != `CCPC_ZERO) ? C_SEND : C_STAT;
			end
			C_SEND: begin
				if (lnk.rsp_ready) begin
					idx_d = idx_q + 8'h01;
					rsp_d = buf_mem[idx_d[`CCPC_BUF_AW-1:0]];
					if (idx_d == len_q)
						st_d = C_STAT;
				end
			end
			C_STAT: st_d = C_IDLE;
			default: st_d = C_IDLE;
		endcase
		// Set wins over the clear of a command in execution
		if (ext_set) begin
			pend_d = 1'b1;
			pend_len_d = min8(ext_len, `CCPC_BUF_DEPTH);
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			st_q <= C_IDLE; ins_q <= '0; p1_q <= '0; p2_q <= '0; lc_q <= '0; le_q <= '0;
			lep_q <= 1'b0; lcp_q <= 1'b0; fid_q <= '0; sw_q <= '0; idx_q <= '0;
			len_q <= '0; rsp_q <= '0; act_q <= '1; ef_q <= '0; ef_ok_q <= 1'b0;
			pend_q <= 1'b0; pend_len_q <= '0; first_q <= 1'b1; pro_len_q <= '0;
			tk_v_q <= 1'b0; tk_k_q <= TK_PROFILE; tk_b_q <= '0;
		end else if (ce) begin
			st_q <= st_d; ins_q <= ins_d; p1_q <= p1_d; p2_q <= p2_d; lc_q <= lc_d;
			le_q <= le_d; lep_q <= lep_d; lcp_q <= lcp_d; fid_q <= fid_d; sw_q <= sw_d;
			idx_q <= idx_d; len_q <= len_d; rsp_q <= rsp_d; act_q <= act_d; ef_q <= ef_d;
			ef_ok_q <= ef_ok_d; pend_q <= pend_d; pend_len_q <= pend_len_d;
			first_q <= first_d; pro_len_q <= pro_len_d;
			tk_v_q <= tk_v_d; tk_k_q <= tk_k_d; tk_b_q <= tk_b_d;
		end
	end

	// Challenge mixed with the key stream stands in for the real algorithm
	always_ff @(posedge core_clk) begin
		if (ce) begin
			if (st_q == C_DATA && lnk.dat_valid && ins_q == `CCPC_INS_AUTH &&
				idx_q < `CCPC_BUF_DEPTH)
				buf_mem[idx_q[`CCPC_BUF_AW-1:0]] <= lnk.dat_byte ^ key_byte;
			else if (ext_wr)
				buf_mem[ext_addr] <= ext_byte;
		end
	end
endmodule // ccpc_card_end

// *** hdl/ccpc_term_end.sv ***
// Terminal end: forces the fixed zero and absent header fields (Lc as requested; Le as requested or last SW2 on auto retrieval), carries data and status
`timescale 1ns/100ps
`include "ccpc_params.svh"
module ccpc_term_end (
	input  wire logic  core_clk,
	input  wire logic  resetn,
	input  wire logic  ce,
	ccpc_link_if.term  lnk,
	input  wire logic  req_valid,
	output logic       req_ready,
	input  wire logic [7:0] req_ins,
	input  wire logic [7:0] req_p1,
	input  wire logic [7:0] req_p2,
	input  wire logic [7:0] req_lc,
	input  wire logic       req_lc_present,
	input  wire logic [7:0] req_le,
	input  wire logic       req_le_present,
	input  wire logic       req_le_auto,
	input  wire logic       tx_valid,
	output logic            tx_ready,
	input  wire logic [7:0] tx_byte,
	output logic            rx_valid,
	output logic [7:0]      rx_byte,
	output logic            done,
	output logic [15:0]     done_sw
);
	import ccpc_pkg::*;

	ccpc_term_st_t st_q, st_d;
	logic [7:0]    ins_q, p1_q, p2_q, lc_q, le_q, ins_d, p1_d, p2_d, lc_d, le_d;
	logic          lcp_q, lcp_d, lep_q, lep_d, rxv_q, rxv_d, done_q, done_d;
	logic [7:0]    cnt_q, cnt_d, rxb_q, rxb_d, sw2_q, sw2_d;
	logic [15:0]   dsw_q, dsw_d;
	logic          zp, no_lc, no_le, is_get;

	function automatic logic ins_is(input logic [7:0] a, input logic [7:0] b);
		return a == b;
	endfunction

	assign is_get = ins_is(req_ins, `CCPC_INS_GETRSP);
	assign zp = ins_is(req_ins, `CCPC_INS_TPROF) || ins_is(req_ins, `CCPC_INS_ENV) ||
		ins_is(req_ins, `CCPC_INS_FETCH) || ins_is(req_ins, `CCPC_INS_TRESP) || is_get;
	assign no_lc = ins_is(req_ins, `CCPC_INS_FETCH) || is_get;
	assign no_le = ins_is(req_ins, `CCPC_INS_REACT) || ins_is(req_ins, `CCPC_INS_TPROF) ||
		ins_is(req_ins, `CCPC_INS_TRESP);

	assign req_ready      = (st_q == T_IDLE);
	assign lnk.cmd_valid  = (st_q == T_HDR);
	assign lnk.ins        = ins_q;
	assign lnk.p1         = p1_q;
	assign lnk.p2         = p2_q;
	assign lnk.lc         = lc_q;
	assign lnk.lc_present = lcp_q;
	assign lnk.le         = le_q;
	assign lnk.le_present = lep_q;
	assign lnk.dat_valid  = (st_q == T_DATA) && tx_valid;
	assign lnk.dat_byte   = tx_byte;
	assign tx_ready       = (st_q == T_DATA) && lnk.dat_ready;
	assign lnk.rsp_ready  = (st_q == T_WAIT);
	assign rx_valid       = rxv_q;
	assign rx_byte        = rxb_q;
	assign done           = done_q;
	assign done_sw        = dsw_q;

	always_comb begin
		st_d = st_q; ins_d = ins_q; p1_d = p1_q; p2_d = p2_q; lc_d = lc_q; le_d = le_q;
		lcp_d = lcp_q; lep_d = lep_q; cnt_d = cnt_q; sw2_d = sw2_q; dsw_d = dsw_q;
		rxv_d = 1'b0; rxb_d = rxb_q; done_d = 1'b0;
		case (st_q)
			T_IDLE: begin
				if (req_valid) begin
					// Toolkit and retrieval commands always carry zero parameters
					ins_d = req_ins;
					p1_d = zp ? `CCPC_ZERO : req_p1;
					p2_d = (zp || ins_is(req_ins, `CCPC_INS_REACT)) ?
						`CCPC_ZERO : req_p2;
					lcp_d = req_lc_present && !no_lc;
					lc_d = lcp_d ? req_lc : `CCPC_ZERO;
					lep_d = req_le_present && !no_le;
					le_d = (is_get && req_le_auto) ? sw2_q : req_le;
					cnt_d = '0;
					st_d = T_HDR;
				end
			end
			T_HDR: begin
				if (lnk.cmd_ready)
					st_d = (lcp_q && lc_q != `CCPC_ZERO) ? T_DATA : T_WAIT;
			end
			T_DATA: begin
				if (tx_valid && lnk.dat_ready) begin
					cnt_d = cnt_q + 8'h01;
					if (cnt_d == lc_q)
						st_d = T_WAIT;
				end
			end
			T_WAIT: begin
				rxv_d = lnk.rsp_valid;
				if (lnk.rsp_valid)
					rxb_d = lnk.rsp_byte;
				if (lnk.sw_valid) begin
					// Remembered for an immediately following retrieval
					sw2_d = lnk.sw[7:0];
					dsw_d = lnk.sw;
					done_d = 1'b1;
					st_d = T_IDLE;
				end
			end
			default: st_d = T_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			st_q <= T_IDLE; ins_q <= '0; p1_q <= '0; p2_q <= '0; lc_q <= '0; le_q <= '0;
			lcp_q <= 1'b0; lep_q <= 1'b0; cnt_q <= '0; sw2_q <= '0; dsw_q <= '0;
			rxv_q <= 1'b0; rxb_q <= '0; done_q <= 1'b0;
		end else if (ce) begin
			st_q <= st_d; ins_q <= ins_d; p1_q <= p1_d; p2_q <= p2_d; lc_q <= lc_d;
			le_q <= le_d; lcp_q <= lcp_d; lep_q <= lep_d; cnt_q <= cnt_d; sw2_q <= sw2_d;
			dsw_q <= dsw_d; rxv_q <= rxv_d; rxb_q <= rxb_d; done_q <= done_d;
		end
	end
endmodule // ccpc_term_end

// *** testbench/ccpc_link_checker.sv ***
// Assertions on the link between the terminal end and the card end
`timescale 1ns/100ps
`include "ccpc_params.svh"
module ccpc_link_checker (
	input wire logic        core_clk,
	input wire logic        resetn,
	input wire logic        cmd_valid,
	input wire logic        cmd_ready,
	input wire logic [7:0]  ins,
	input wire logic [7:0]  p1,
	input wire logic [7:0]  p2,
	input wire logic [7:0]  lc,
	input wire logic        lc_present,
	input wire logic        le_present,
	input wire logic        rsp_valid,
	input wire logic        rsp_ready,
	input wire logic [7:0]  rsp_byte,
	input wire logic        sw_valid,
	input wire logic [15:0] sw
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	logic [7:0] h_ins_q;
	logic [7:0] h_p1_q;
	logic [7:0] h_p2_q;
	// Header kept so the status can be judged against what was asked
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			{h_ins_q, h_p1_q, h_p2_q} <= 24'h000000;
		end else if (cmd_valid && cmd_ready) begin
			{h_ins_q, h_p1_q, h_p2_q} <= {ins, p1, p2};
		end
	end
	a_react_hdr: assert property (cmd_valid && ins == `CCPC_INS_REACT |->
		p2 == 8'h00 && !le_present) else $error("reactivation header malformed");
	a_tk_hdr: assert property (cmd_valid && (ins == `CCPC_INS_TPROF ||
		ins == `CCPC_INS_TRESP) |-> p1 == 8'h00 && p2 == 8'h00 && !le_present)
		else $error("toolkit header malformed");
	a_env_hdr: assert property (cmd_valid && ins == `CCPC_INS_ENV |->
		p1 == 8'h00 && p2 == 8'h00 && lc_present) else $error("toolkit_cmd_a header malformed");
	a_fetch_hdr: assert property (cmd_valid && ins == `CCPC_INS_FETCH |->
		p1 == 8'h00 && p2 == 8'h00 && !lc_present && le_present)
		else $error("fetch header malformed");
	a_rtv_hdr: assert property (cmd_valid && ins == `CCPC_INS_GETRSP |->
		p1 == 8'h00 && p2 == 8'h00 && !lc_present) else $error("retrieval header malformed");
	a_auth_badp: assert property (sw_valid && h_ins_q == `CCPC_INS_AUTH &&
		(h_p1_q != 8'h00 || h_p2_q[6:5] != 2'b00) |-> sw == `CCPC_SW_BADP)
		else $error("bad authentication parameter accepted");
	a_react_badp: assert property (sw_valid && h_ins_q == `CCPC_INS_REACT &&
		!(h_p1_q inside {8'h00, 8'h08, 8'h09}) |-> sw == `CCPC_SW_BADP)
		else $error("reserved selection control accepted");
	a_stat_lat: assert property (cmd_valid && cmd_ready && !(lc_present && lc != 8'h00)
		&& ins != `CCPC_INS_FETCH && ins != `CCPC_INS_GETRSP |-> ##2 sw_valid)
		else $error("status late for command without data");
	a_sw_once: assert property (sw_valid |=> !sw_valid && cmd_ready)
		else $error("status not a single pulse before idle");
	a_rsp_hold: assert property (rsp_valid |=> rsp_valid || sw_valid)
		else $error("response stream broken before status");
endmodule // ccpc_link_checker

// *** testbench/card_command_param_checker_tb.sv ***
// Self-checking bench joining terminal end and card end
`timescale 1ns/100ps
`include "ccpc_params.svh"
module card_command_param_checker_tb;
	import ccpc_pkg::*;
	logic          core_clk, resetn, ce, cur_ef_valid, key_specific, key_implicit, tk_valid;
	logic [3:0]    ac_ok, deact_req, lcs_active, act;
	logic [1:0]    cur_ef;
	logic [4:0]    key_ref, ext_addr;
	logic [7:0]    key_byte, tk_byte, ext_byte, ext_len, pro_len, tx_byte, rx_byte;
	ccpc_tk_kind_t tk_kind;
	logic          ext_wr, ext_set, pro_set, req_valid, req_ready, req_lc_present;
	logic          req_le_present, req_le_auto, tx_valid, tx_ready, rx_valid, done, cv;
	logic [7:0]    req_ins, req_p1, req_p2, req_lc, req_le, a, b;
	logic [15:0]   done_sw, s;
	logic [31:0]   rng = 32'hdd85ffa5;
	logic [7:0]    txq[$], rxq[$], expq[$];
	logic [9:0]    tkq[$];
	int            n_mismatch = 0, check_count = 0, cyc = 0, cur = 0, n, x;
	ccpc_link_if lnk ();
	ccpc_card_end u_ccpc_card_end (.core_clk, .resetn, .ce, .lnk(lnk.card), .ac_ok, .deact_req,
		.lcs_active, .cur_ef, .cur_ef_valid, .key_specific, .key_implicit, .key_ref, .key_byte,
		.tk_valid, .tk_kind, .tk_byte, .ext_wr, .ext_addr, .ext_byte, .ext_set, .ext_len,
		.pro_set, .pro_len);
	ccpc_term_end u_ccpc_term_end (.core_clk, .resetn, .ce, .lnk(lnk.term), .req_valid,
		.req_ready, .req_ins, .req_p1, .req_p2, .req_lc, .req_lc_present, .req_le,
		.req_le_present, .req_le_auto, .tx_valid, .tx_ready, .tx_byte, .rx_valid, .rx_byte,
		.done, .done_sw);
	ccpc_link_checker u_chk (.core_clk, .resetn, .cmd_valid(lnk.cmd_valid),
		.cmd_ready(lnk.cmd_ready), .ins(lnk.ins), .p1(lnk.p1), .p2(lnk.p2), .lc(lnk.lc),
		.lc_present(lnk.lc_present), .le_present(lnk.le_present), .rsp_valid(lnk.rsp_valid),
		.rsp_ready(lnk.rsp_ready), .rsp_byte(lnk.rsp_byte), .sw_valid(lnk.sw_valid),
		.sw(lnk.sw));
	initial begin
		core_clk = 0;
		forever #25 core_clk = ~core_clk;
	end
	function automatic logic [7:0] rnd();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng[7:0];
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	always @(posedge core_clk) begin
		cyc++;
		if (rx_valid === 1'b1) rxq.push_back(rx_byte);
		if (tk_valid === 1'b1) tkq.push_back({tk_kind, tk_byte});
		if (cyc == 5000) begin
			n_mismatch++;
			final_report();
		end
	end
	// Header held until taken; data bytes held until the card accepts them
	task automatic cmd(input logic [7:0] i, p, q, l, e, input logic lp, ep);
		int k;
		k = 0;
		rxq = {};
		tkq = {};
		@(negedge core_clk);
		{req_ins, req_p1, req_p2, req_lc, req_le} = {i, p, q, l, e};
		{req_lc_present, req_le_present, req_valid} = {lp, ep, 1'b1};
		@(posedge core_clk);
		while (req_ready !== 1'b1) @(posedge core_clk);
		for (int m = 0; m < 300; m++) begin
			@(negedge core_clk);
			req_valid = 0;
			tx_valid = (k < txq.size());
			tx_byte = tx_valid ? txq[k] : rnd();
			@(posedge core_clk);
			if (tx_valid && tx_ready === 1'b1) k++;
			if (done === 1'b1) break;
		end
		s = done_sw;
		@(negedge core_clk);
		tx_valid = 0;
		txq = {};
	endtask
	task automatic deact(input int f);
		@(negedge core_clk) deact_req = 4'h1 << f;
		@(negedge core_clk) deact_req = 4'h0;
		act[f] = 0;
	endtask
	// Model of reactivation: selection control, target, access, current file
	task automatic react(input logic [7:0] p, input int f, input int nb);
		int t;
		logic [15:0] e;
		t = (nb == 0) ? cur : f;
		if (nb == 4) txq = {8'h3f, 8'h00, 8'h6f, 8'(f)};
		else if (nb == 2) txq = {8'h6f, 8'(f)};
		else txq = {};
		cmd(`CCPC_INS_REACT, p, 8'h00, 8'(nb), 8'h00, nb != 0, 1'b0);
		e = !(p inside {8'h00, 8'h08, 8'h09}) ? `CCPC_SW_BADP :
			!ac_ok[t] ? `CCPC_SW_ACCESS : `CCPC_SW_OK;
		if (e == `CCPC_SW_OK) {act[t], cv, cur} = {2'b11, t};
		chk(s, e);
		chk({cur_ef_valid, cur_ef, lcs_active}, {cv, 2'(cur), act});
	endtask
	task automatic rxcmp(input int c);
		chk(rxq.size(), c);
		for (int k = 0; k < c; k++) chk(rxq[k], expq[k]);
	endtask
	initial begin
		{ce, ac_ok, act, deact_req, cv, key_byte, ext_wr, ext_addr, ext_byte} = {1'b1, 8'hff, 27'h0};
		{ext_set, ext_len, pro_set, pro_len, req_valid, tx_valid, tx_byte} = 28'h0;
		{req_ins, req_p1, req_p2, req_lc, req_le, req_lc_present, req_le_present} = 42'h0;
		{req_le_auto, resetn} = 2'b00;
		repeat (12) @(posedge core_clk);
		@(negedge core_clk) resetn = 1;
		cmd(`CCPC_INS_GETRSP, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 1'b1);
		chk(s, `CCPC_SW_OK);
		deact(2);
		ac_ok = 4'hb;
		react(8'h00, 2, 2);
		ac_ok = 4'hf;
		for (int j = 0; j < 3; j++) begin
			deact(j);
			react(j == 0 ? 8'h00 : 8'h07 + j[7:0], j, j == 0 ? 2 : 4);
		end
		deact(2);
		react(8'h00, 0, 0);
		for (int j = 0; j < 4; j++) react(j == 0 ? 8'h05 : rnd(), 1, 2);
		// Clock enable low must freeze the lifecycle flags
		@(negedge core_clk) {ce, deact_req} = {1'b0, 4'hf};
		@(negedge core_clk) {ce, deact_req} = {1'b1, 4'h0};
		chk(lcs_active, act);
		$display("test reactivation done");
		for (int t = 0; t < 6; t++) begin
			n = 1 + rnd() % 8;
			x = 1 + rnd() % n;
			a = (t == 5) ? 8'h01 : 8'h00;
			b = (t == 0) ? 8'h00 : {rnd() > 8'h7f, t == 4 ? 2'b01 : 2'b00, 5'(1 + rnd() % 31)};
			key_byte = rnd();
			expq = {};
			for (int k = 0; k < n; k++) txq.push_back(rnd());
			foreach (txq[k]) expq.push_back(txq[k] ^ key_byte);
			cmd(`CCPC_INS_AUTH, a, b, 8'(n), 8'(x), 1'b1, t[0]);
			if (!t[0]) x = n;
			if (t >= 4) chk(s, `CCPC_SW_BADP);
			else begin
				chk(s, {`CCPC_SW1_AVAIL, 8'(x)});
				chk({key_implicit, key_specific, key_ref}, {b == 0, b[7], b[4:0]});
				if (t == 1) cmd(`CCPC_INS_GETRSP, 8'h0, 8'h0, 8'h0, 8'(x + 1), 1'b0, 1'b1);
				if (t == 1) chk(s, {`CCPC_SW1_RELEN, 8'(x)});
				req_le_auto = 1;
				cmd(`CCPC_INS_GETRSP, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 1'b1);
				req_le_auto = 0;
				chk(s, `CCPC_SW_OK);
				rxcmp(x);
			end
		end
		$display("test authentication done");
		for (int k = 0; k < 3; k++) begin
			n = 1 + rnd() % 4;
			for (int m = 0; m < n; m++) txq.push_back(rnd());
			expq = txq;
			cmd(k == 0 ? 8'h03 : k == 1 ? 8'h04 : 8'h06, 8'h0, 8'h0, 8'(n), 8'h0, 1'b1, 1'b0);
			chk(s, `CCPC_SW_OK);
			chk(tkq.size(), n);
			foreach (expq[m]) chk(tkq[m], {2'(k), expq[m]});
		end
		cmd(`CCPC_INS_GETRSP, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 1'b1);
		chk(s, `CCPC_SW_TECH);
		$display("test toolkit and sequence done");
		expq = {};
		for (int k = 0; k < 6; k++) begin
			@(negedge core_clk) {ext_wr, ext_addr, ext_byte} = {1'b1, 5'(k), rnd()};
			expq.push_back(ext_byte);
		end
		@(negedge core_clk) {ext_wr, pro_set, pro_len} = {2'b01, 8'h06};
		@(negedge core_clk) pro_set = 0;
		cmd(`CCPC_INS_FETCH, 8'h00, 8'h00, 8'h00, 8'h06, 1'b0, 1'b1);
		chk(s, `CCPC_SW_OK);
		rxcmp(6);
		@(negedge core_clk) {ext_set, ext_len} = {1'b1, 8'h05};
		@(negedge core_clk) ext_set = 0;
		cmd(`CCPC_INS_GETRSP, 8'h00, 8'h00, 8'h00, 8'h05, 1'b0, 1'b1);
		chk(s, `CCPC_SW_OK);
		rxcmp(5);
		$display("test fetch and retrieval done");
		final_report();
	end
endmodule // card_command_param_checker_tb
